// >>> design/io_settle_check.sv
// Per-axis I/O pattern handling and end-of-move settle checking, APB slave.
// Assumes synchronous field inputs and a motion core that pulses MOVE_DONE at trajectory end.
module io_settle_check (
    input  wire logic                    MCLK,
    input  wire logic                    RST_N,
    input  wire logic                    PSEL,
    input  wire logic                    PENABLE,
    input  wire logic                    PWRITE,
    input  wire logic [7:0]              PADDR,
    input  wire logic [31:0]             PWDATA,
    output logic      [31:0]             PRDATA,
    output logic                         PREADY,
    output logic                         PSLVERR,
    input  wire logic [7:0]              READ_PORT,
    output logic      [7:0]              WRITE_PORT,
    input  wire io_settle_pkg::position_t POSITION,
    input  wire logic                    MOVE_DONE,
    input  wire logic                    DELAY_BUSY,
    output logic                         CORRECT_MOVE,
    output logic                         MOVE_ABORT,
    output logic                         IRQ
);
    io_settle_pkg::mode_t         mode;
    io_settle_pkg::cmd_state_t    cmd_state;
    io_settle_pkg::settle_state_t settle_state;
    io_settle_pkg::pattern_t      pattern;
    logic [31:0]                  settle_window;
    logic [31:0]                  settling_time;
    logic [31:0]                  settle_count;
    logic [io_settle_pkg::EV_BITS-1:0] irq_stat;
    logic [io_settle_pkg::EV_BITS-1:0] irq_mask;
    logic [io_settle_pkg::EV_BITS-1:0] ev;
    logic [2:0]                   cmd_code;
    logic                         wr;
    logic                         rd;
    logic                         pat_valid;
    logic                         in_match;
    logic [7:0]                   next_out;
    logic                         in_window;
    logic [31:0]                  diff;
    logic [31:0]                  abs_diff;
    logic                         axis_idle;
    logic                         uses_window;

    assign wr      = PSEL && PENABLE && PWRITE;
    assign rd      = PSEL && PENABLE && !PWRITE;
    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;
    assign IRQ     = |(irq_stat & irq_mask);
    assign axis_idle = (settle_state == io_settle_pkg::ST_IDLE) && !DELAY_BUSY;

    // Pattern check: valid digits only, digits beyond count read as low
    always_comb begin
        pat_valid = (pattern.count <= io_settle_pkg::PAT_DIGITS_MAX);
        in_match  = 1'b1;
        next_out  = WRITE_PORT;
        for (int i = 0; i < 8; i++) begin
            logic [1:0] d;
            d = pattern.digits[2*i +: 2];
            if (i >= int'(pattern.count)) begin
                d = io_settle_pkg::DIGIT_LOW;
            end
            if (d == 2'h3) begin
                pat_valid = 1'b0;
            end
            if (d == io_settle_pkg::DIGIT_LOW && READ_PORT[i]) begin
                in_match = 1'b0;
            end
            if (d == io_settle_pkg::DIGIT_HIGH && !READ_PORT[i]) begin
                in_match = 1'b0;
            end
            // Digit i drives write port i+1, so digit 7 is port 8
            if (d == io_settle_pkg::DIGIT_LOW) begin
                next_out[i] = 1'b0;
            end else if (d == io_settle_pkg::DIGIT_HIGH) begin
                next_out[i] = 1'b1;
            end
        end
    end

    // Inclusive, symmetric window test on signed difference
    always_comb begin
        diff      = POSITION.actual - POSITION.command;
        abs_diff  = diff[31] ? (32'h0 - diff) : diff;
        in_window = (abs_diff <= settle_window);
    end

    assign uses_window = (mode != io_settle_pkg::OPEN_LOOP_STEPPER_MODE);

    // Command sequencer: one command at a time; writes to CMD while busy are dropped
    always_comb begin
        ev = '0;
        cmd_code = PWDATA[2:0];
        if (wr && PADDR == io_settle_pkg::ADDR_CMD && cmd_state == io_settle_pkg::CMD_IDLE) begin
            if ((cmd_code == io_settle_pkg::CMD_WAIT_IN || cmd_code == io_settle_pkg::CMD_WRITE_OUT)
                && !pat_valid) begin
                ev[io_settle_pkg::EV_INVALID] = 1'b1;
            end
        end
        if (cmd_state == io_settle_pkg::CMD_DONE) begin
            ev[io_settle_pkg::EV_ACK] = 1'b1;
        end
        if (wr && PADDR == io_settle_pkg::ADDR_WINDOW &&
            (PWDATA > io_settle_pkg::WINDOW_MAX || !axis_idle)) begin
            ev[io_settle_pkg::EV_RANGE] = 1'b1;
        end
        if (settle_state == io_settle_pkg::ST_SETTLE && settle_count == 32'h0) begin
            if (in_window) begin
                ev[io_settle_pkg::EV_COMPLETE] = 1'b1;
            end else if (mode == io_settle_pkg::CHECKING_STEPPER_MODE) begin
                ev[io_settle_pkg::EV_ABORT] = 1'b1;
            end else if (mode == io_settle_pkg::CLOSED_LOOP_STEPPER_MODE) begin
                ev[io_settle_pkg::EV_CORRECT] = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cmd_state <= io_settle_pkg::CMD_IDLE;
        end else begin
            case (cmd_state)
                io_settle_pkg::CMD_IDLE: begin
                    if (wr && PADDR == io_settle_pkg::ADDR_CMD) begin
                        case (cmd_code)
                            io_settle_pkg::CMD_WAIT_IN:
                                cmd_state <= pat_valid ? io_settle_pkg::CMD_WAIT
                                                       : io_settle_pkg::CMD_IDLE;
                            io_settle_pkg::CMD_WAIT_END:
                                cmd_state <= io_settle_pkg::CMD_END;
                            io_settle_pkg::CMD_WRITE_OUT:
                                cmd_state <= pat_valid ? io_settle_pkg::CMD_DONE
                                                       : io_settle_pkg::CMD_IDLE;
                            default:
                                cmd_state <= io_settle_pkg::CMD_IDLE;
                        endcase
                    end
                end
                io_settle_pkg::CMD_WAIT: begin
                    if (in_match) begin
                        cmd_state <= io_settle_pkg::CMD_DONE;
                    end
                end
                io_settle_pkg::CMD_END: begin
                    // Held in a MOVE_DONE cycle so a just-ended move is seen settling
                    if (axis_idle && !MOVE_DONE) begin
                        cmd_state <= io_settle_pkg::CMD_DONE;
                    end
                end
                io_settle_pkg::CMD_DONE: cmd_state <= io_settle_pkg::CMD_IDLE;
                default: cmd_state <= io_settle_pkg::CMD_IDLE;
            endcase
        end
    end

    // Write ports: off at reset, masked update only on a valid pattern
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            WRITE_PORT <= 8'h00;
        end else if (wr && PADDR == io_settle_pkg::ADDR_CMD &&
                     cmd_state == io_settle_pkg::CMD_IDLE &&
                     cmd_code == io_settle_pkg::CMD_WRITE_OUT && pat_valid) begin
            WRITE_PORT <= next_out;
        end
    end

    // Configuration registers; pattern frozen while a command uses it
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            mode          <= io_settle_pkg::SERVO_MODE;
            pattern       <= '0;
            settle_window <= io_settle_pkg::WINDOW_RESET;
            settling_time <= io_settle_pkg::SETTLE_RESET;
            irq_mask      <= '0;
        end else if (wr) begin
            case (PADDR)
                io_settle_pkg::ADDR_CTRL: begin
                    if (axis_idle) begin
                        mode <= io_settle_pkg::mode_t'(PWDATA[2:0]);
                    end
                end
                io_settle_pkg::ADDR_PATTERN: begin
                    if (cmd_state == io_settle_pkg::CMD_IDLE) begin
                        pattern <= io_settle_pkg::pattern_t'(PWDATA[20:0]);
                    end
                end
                io_settle_pkg::ADDR_WINDOW: begin
                    if (axis_idle && PWDATA <= io_settle_pkg::WINDOW_MAX) begin
                        settle_window <= PWDATA;
                    end
                end
                io_settle_pkg::ADDR_SETTLE:   settling_time <= PWDATA;
                io_settle_pkg::ADDR_IRQ_MASK: irq_mask <= PWDATA[io_settle_pkg::EV_BITS-1:0];
                default: ;
            endcase
        end
    end

    // Settle state machine
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            settle_state <= io_settle_pkg::ST_IDLE;
            settle_count <= 32'h0;
            CORRECT_MOVE <= 1'b0;
            MOVE_ABORT   <= 1'b0;
        end else begin
            CORRECT_MOVE <= 1'b0;
            MOVE_ABORT   <= 1'b0;
            case (settle_state)
                io_settle_pkg::ST_IDLE: begin
                    if (MOVE_DONE) begin
                        settle_state <= uses_window ? io_settle_pkg::ST_SETTLE
                                                    : io_settle_pkg::ST_IDLE;
                        settle_count <= settling_time;
                    end
                end
                io_settle_pkg::ST_MOVING: begin
                    // Correction move in progress until the core reports its end
                    if (MOVE_DONE) begin
                        settle_state <= io_settle_pkg::ST_SETTLE;
                        settle_count <= settling_time;
                    end
                end
                io_settle_pkg::ST_SETTLE: begin
                    if (mode == io_settle_pkg::SERVO_MODE ||
                        mode == io_settle_pkg::EXTERNAL_LOOP_STEPPER_MODE) begin
                        if (!in_window) begin
                            settle_count <= settling_time;
                        end else if (settle_count == 32'h0) begin
                            settle_state <= io_settle_pkg::ST_IDLE;
                        end else begin
                            settle_count <= settle_count - 32'h1;
                        end
                    end else if (settle_count != 32'h0) begin
                        settle_count <= settle_count - 32'h1;
                    end else if (in_window) begin
                        settle_state <= io_settle_pkg::ST_IDLE;
                    end else if (mode == io_settle_pkg::CLOSED_LOOP_STEPPER_MODE) begin
                        settle_state <= io_settle_pkg::ST_MOVING;
                        CORRECT_MOVE <= 1'b1;
                    end else begin
                        settle_state <= io_settle_pkg::ST_IDLE;
                        MOVE_ABORT   <= 1'b1;
                    end
                end
                default: settle_state <= io_settle_pkg::ST_IDLE;
            endcase
        end
    end

    // Sticky status; a read clears only the bits it reported, so an event
    // raised between setup and access is kept, and a same-cycle event wins
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat <= '0;
        end else if (rd && PADDR == io_settle_pkg::ADDR_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~PRDATA[io_settle_pkg::EV_BITS-1:0]) | ev;
        end else begin
            irq_stat <= irq_stat | ev;
        end
    end

    // Read data registered on the setup cycle; zero-wait so PREADY is constant
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= 32'h0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                io_settle_pkg::ADDR_CTRL:     PRDATA <= {29'h0, mode};
                io_settle_pkg::ADDR_PATTERN:  PRDATA <= {11'h0, pattern};
                io_settle_pkg::ADDR_WINDOW:   PRDATA <= settle_window;
                io_settle_pkg::ADDR_SETTLE:   PRDATA <= settling_time;
                io_settle_pkg::ADDR_STATUS:   PRDATA <= {25'h0, in_window, in_match,
                                                         settle_state, 1'b0,
                                                         cmd_state == io_settle_pkg::CMD_IDLE};
                io_settle_pkg::ADDR_IRQ_STAT: PRDATA <= {26'h0, irq_stat};
                io_settle_pkg::ADDR_IRQ_MASK: PRDATA <= {26'h0, irq_mask};
                io_settle_pkg::ADDR_OUTPORT:  PRDATA <= {24'h0, WRITE_PORT};
                io_settle_pkg::ADDR_INPORT:   PRDATA <= {24'h0, READ_PORT};
                default:                      PRDATA <= 32'h0;
            endcase
        end
    end
endmodule

// >>> shared/io_settle_pkg.sv
// Constants, register map and carrier types of the I/O pattern and settle check block.
// Assumes a single 100 MHz clock domain and an APB master that holds each request until ready.
// How it works
// - Wait-inputs command stalls until inputs match pattern
// - No further command runs while wait pending
// - Ternary digit per port: low, high, ignore
// - Missing leading digits are treated as low
// - Bad digit or too many digits: invalid-binary
// - Wait-for-end stalls until axis idle again
// - Servo: in window, settle countdown, then complete
// - Servo: leaving window reloads settle countdown
// - External-loop stepper behaves exactly like servo
// - Checking stepper: count down, then complete or abort
// - Closed-loop stepper: outside window starts correction move
// - Open-loop stepper never uses window checking
// - Window 0..2147483647, default 4, idle-only writes
// - Write-outputs: digit 0 off, 1 on, 2 keep
// - Output digits map port 8 down to 1
// - All write ports off after power-up
// - Bad output pattern: invalid-binary, outputs unchanged
package io_settle_pkg;
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_CMD      = 8'h04;
    localparam logic [7:0]  ADDR_PATTERN  = 8'h08;
    localparam logic [7:0]  ADDR_WINDOW   = 8'h0C;
    localparam logic [7:0]  ADDR_SETTLE   = 8'h10;
    localparam logic [7:0]  ADDR_STATUS   = 8'h14;
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0]  ADDR_IRQ_MASK = 8'h1C;
    localparam logic [7:0]  ADDR_OUTPORT  = 8'h20;
    localparam logic [7:0]  ADDR_INPORT   = 8'h24;

    localparam logic [31:0] WINDOW_RESET  = 32'h0000_0004;
    localparam logic [31:0] WINDOW_MAX    = 32'h7FFF_FFFF;
    localparam logic [31:0] SETTLE_RESET  = 32'h0000_0064;
    localparam logic [4:0]  PAT_DIGITS_MAX = 5'h08;
    localparam logic [1:0]  DIGIT_LOW     = 2'h0;
    localparam logic [1:0]  DIGIT_HIGH    = 2'h1;
    localparam logic [1:0]  DIGIT_ANY     = 2'h2;

    // Command codes written to ADDR_CMD
    localparam logic [2:0]  CMD_WAIT_IN   = 3'h1;
    localparam logic [2:0]  CMD_WAIT_END  = 3'h2;
    localparam logic [2:0]  CMD_WRITE_OUT = 3'h3;
    localparam logic [2:0]  CMD_SET_WIN   = 3'h4;

    // Sticky event bits
    localparam int EV_ACK      = 0;
    localparam int EV_INVALID  = 1;
    localparam int EV_RANGE    = 2;
    localparam int EV_COMPLETE = 3;
    localparam int EV_ABORT    = 4;
    localparam int EV_CORRECT  = 5;
    localparam int EV_BITS     = 6;

    typedef enum logic [2:0] {
        SERVO_MODE                 = 3'h0,
        OPEN_LOOP_STEPPER_MODE     = 3'h1,
        CHECKING_STEPPER_MODE      = 3'h2,
        EXTERNAL_LOOP_STEPPER_MODE = 3'h3,
        CLOSED_LOOP_STEPPER_MODE   = 3'h4
    } mode_t;

    typedef enum logic [3:0] {
        CMD_IDLE = 4'b0001,
        CMD_WAIT = 4'b0010,
        CMD_END  = 4'b0100,
        CMD_DONE = 4'b1000
    } cmd_state_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_MOVING = 3'b010,
        ST_SETTLE = 3'b100
    } settle_state_t;

    // Ternary pattern: two bits per digit, digit 7 is port 8
    typedef struct packed {
        logic [4:0]  count;
        logic [15:0] digits;
    } pattern_t;

    typedef struct packed {
        logic        [31:0] actual;
        logic        [31:0] command;
    } position_t;
endpackage

// >>> sim/axis_model.sv
// Motion core model: ends moves on request and answers correction requests.
// Assumes the bench calls its tasks right after a rising clock edge.
module axis_model (
    input  wire logic               mclk,
    input  wire logic               correct_move,
    output io_settle_pkg::position_t position,
    output logic                    move_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic signed [31:0] off = 32'sh0;
    assign position = {32'h0000_1000 + off, 32'h0000_1000};
    initial move_done = 1'b0;
    task automatic set_off(input int v);
        off <= v;
    endtask
    task automatic end_move;
        move_done <= 1'b1;
        @(posedge mclk);
        move_done <= 1'b0;
    endtask
    // Correction lands on target, then ends again after a short travel
    always @(posedge mclk) begin
        if (correct_move === 1'b1) begin
            repeat (3) @(posedge mclk);
            off <= 32'sh0;
            end_move();
        end
    end
endmodule

// >>> sim/io_settle_monitor.sv
// Checker for the I/O pattern and settle block, bound to its top module.
// Assumes all watched outputs change only on rising MCLK edges.
module io_settle_monitor (
    input wire logic                     MCLK,
    input wire logic                     RST_N,
    input wire logic                     PSEL,
    input wire logic                     PENABLE,
    input wire logic                     PWRITE,
    input wire logic [7:0]               PADDR,
    input wire logic [7:0]               WRITE_PORT,
    input wire io_settle_pkg::position_t POSITION,
    input wire logic                     MOVE_DONE,
    input wire logic                     CORRECT_MOVE,
    input wire logic                     MOVE_ABORT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cmd_wr;
    assign cmd_wr = PSEL && PENABLE && PWRITE && (PADDR == io_settle_pkg::ADDR_CMD);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // A move end needs at least the load cycle before any outcome
    sequence no_outcome;
        !MOVE_ABORT && !CORRECT_MOVE;
    endsequence
    AST_OUT_RESET: assert property ($rose(RST_N) |-> WRITE_PORT == 8'h00)
        else $error("write ports not off after reset");
    AST_OUT_CHANGE: assert property (!$stable(WRITE_PORT) |-> $past(cmd_wr))
        else $error("write ports changed without a command write");
    AST_ABORT_PULSE: assert property (MOVE_ABORT |=> !MOVE_ABORT)
        else $error("abort pulse longer than one cycle");
    AST_CORRECT_PULSE: assert property (CORRECT_MOVE |=> !CORRECT_MOVE)
        else $error("correction pulse longer than one cycle");
    AST_ONE_OUTCOME: assert property (!(MOVE_ABORT && CORRECT_MOVE))
        else $error("abort and correction together");
    AST_ABORT_POS: assert property (MOVE_ABORT |-> $past(POSITION.actual != POSITION.command))
        else $error("abort with position on target");
    AST_CORRECT_POS: assert property (CORRECT_MOVE |-> $past(POSITION.actual != POSITION.command))
        else $error("correction with position on target");
    AST_NO_EARLY: assert property (MOVE_DONE |=> no_outcome)
        else $error("outcome before settling started");
endmodule

bind io_settle_check io_settle_monitor mon (
    .MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .WRITE_PORT(WRITE_PORT), .POSITION(POSITION), .MOVE_DONE(MOVE_DONE),
    .CORRECT_MOVE(CORRECT_MOVE), .MOVE_ABORT(MOVE_ABORT)
);

// >>> sim/testbench.sv
// Self-checking bench: APB tasks, field inputs and a motion core model.
// Assumes zero-wait APB and command acks shown in STATUS bit 0.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     mclk = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     psel = 1'b0;
    logic                     penable = 1'b0;
    logic                     pwrite = 1'b0;
    logic                     delay_busy = 1'b0;
    logic [7:0]               paddr = 8'h00;
    logic [7:0]               read_port = 8'h00;
    logic [31:0]              pwdata = 32'h0;
    logic [31:0]              q;
    logic [31:0]              prdata;
    logic [7:0]               write_port;
    logic                     pready, correct_move, move_abort, irq, move_done;
    io_settle_pkg::position_t position;
    int                       error_cnt = 0;
    int                       tests_run = 0;
    logic [2:0]               md [4] = '{3'h2, 3'h2, 3'h4, 3'h1};
    int                       offs [4] = '{9, 0, 9, 9};
    logic [31:0]              ex [4] = '{32'h10, 32'h08, 32'h28, 32'h00};

    always #5 mclk = ~mclk;

    io_settle_check dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(), .READ_PORT(read_port), .WRITE_PORT(write_port), .POSITION(position),
        .MOVE_DONE(move_done), .DELAY_BUSY(delay_busy), .CORRECT_MOVE(correct_move),
        .MOVE_ABORT(move_abort), .IRQ(irq));
    axis_model axis (.mclk(mclk), .correct_move(correct_move), .position(position),
        .move_done(move_done));

    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Request held until pready is seen; an idle edge follows so psel never toggles twice
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    function automatic logic [31:0] pat(input logic [31:0] h, input int n);
        logic [15:0] d;
        for (int i = 0; i < 8; i++) d[2*i+:2] = h[4*i+:2];
        return {11'h0, n[4:0], d};
    endfunction
    task automatic cmd(input logic [31:0] p, input logic [2:0] c);
        wr(io_settle_pkg::ADDR_PATTERN, p);
        wr(io_settle_pkg::ADDR_CMD, {29'h0, c});
    endtask
    task automatic wait_ack;
        int n;
        n = 0;
        do begin
            rd(io_settle_pkg::ADDR_STATUS);
            n++;
        end while (q[0] !== 1'b1 && n < 100);
        chk(q[0], 1, "command ack");
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk(write_port, 0, "ports after reset");
        rd(io_settle_pkg::ADDR_WINDOW);
        chk(q, 32'h4, "window reset");
        rd(8'h3C);
        chk(q, 0, "unmapped read");
        wr(io_settle_pkg::ADDR_SETTLE, 32'hA);
        $display("reset test done");
        cmd(pat(32'h00110111, 8), io_settle_pkg::CMD_WRITE_OUT);
        wait_ack();
        chk(write_port, 32'h37, "outputs set");
        cmd(pat(32'h12001200, 8), io_settle_pkg::CMD_WRITE_OUT);
        wait_ack();
        chk(write_port, 32'h8C, "keep digits");
        cmd(pat(32'h21, 2), io_settle_pkg::CMD_WRITE_OUT);
        wait_ack();
        chk(write_port, 32'h01, "short pattern");
        // Bad digit, then too many digits, on both pattern commands
        for (int i = 0; i < 4; i++) begin
            rd(io_settle_pkg::ADDR_IRQ_STAT);
            cmd(i[0] ? pat(32'h1, 9) : pat(32'h3, 1), i[1] ? 3'h1 : 3'h3);
            rd(io_settle_pkg::ADDR_IRQ_STAT);
            chk(q & 32'h2, 32'h2, "invalid pattern");
            chk(write_port, 32'h01, "outputs kept");
        end
        $display("output test done");
        read_port <= 8'hB0;
        cmd(pat(32'h22112210, 8), io_settle_pkg::CMD_WAIT_IN);
        rd(io_settle_pkg::ADDR_STATUS);
        chk(q[0], 0, "wait pending");
        wr(io_settle_pkg::ADDR_CMD, 32'h3);
        chk(write_port, 32'h01, "command while waiting");
        read_port <= 8'hF2;
        wait_ack();
        read_port <= 8'h03;
        cmd(pat(32'h1, 1), io_settle_pkg::CMD_WAIT_IN);
        repeat (5) @(posedge mclk);
        rd(io_settle_pkg::ADDR_STATUS);
        chk(q[0], 0, "leading digits low");
        read_port <= 8'h01;
        wait_ack();
        $display("input wait test done");
        wr(io_settle_pkg::ADDR_WINDOW, 32'h8000_0000);
        rd(io_settle_pkg::ADDR_WINDOW);
        chk(q, 32'h4, "window refused");
        rd(io_settle_pkg::ADDR_IRQ_STAT);
        chk(q & 32'h4, 32'h4, "range event");
        wr(io_settle_pkg::ADDR_WINDOW, 32'h7FFF_FFFF);
        rd(io_settle_pkg::ADDR_WINDOW);
        chk(q, 32'h7FFF_FFFF, "window max");
        wr(io_settle_pkg::ADDR_WINDOW, 32'h4);
        delay_busy <= 1'b1;
        wr(io_settle_pkg::ADDR_CMD, 32'h2);
        repeat (10) @(posedge mclk);
        rd(io_settle_pkg::ADDR_STATUS);
        chk(q[0], 0, "wait end during delay");
        delay_busy <= 1'b0;
        wait_ack();
        $display("window and delay test done");
        // Servo, then external loop: a dip out of window restarts settling
        for (int m = 0; m < 4; m += 3) begin
            wr(io_settle_pkg::ADDR_CTRL, m);
            axis.set_off(7);
            axis.end_move();
            repeat (20) @(posedge mclk);
            rd(io_settle_pkg::ADDR_IRQ_STAT);
            chk(q & 32'h8, 0, "out of window");
            axis.set_off(-4);
            repeat (5) @(posedge mclk);
            axis.set_off(5);
            repeat (5) @(posedge mclk);
            axis.set_off(4);
            repeat (5) @(posedge mclk);
            rd(io_settle_pkg::ADDR_IRQ_STAT);
            chk(q & 32'h8, 0, "settling restarted");
            wr(io_settle_pkg::ADDR_CMD, 32'h2);
            wait_ack();
            rd(io_settle_pkg::ADDR_IRQ_STAT);
            chk(q & 32'h8, 32'h8, "complete");
        end
        // Checking out and in, closed-loop out, open-loop out
        for (int i = 0; i < 4; i++) begin
            wr(io_settle_pkg::ADDR_CTRL, {29'h0, md[i]});
            rd(io_settle_pkg::ADDR_IRQ_STAT);
            axis.set_off(offs[i]);
            axis.end_move();
            repeat (40) @(posedge mclk);
            rd(io_settle_pkg::ADDR_IRQ_STAT);
            chk(q & 32'h38, ex[i], "move outcome");
        end
        $display("settle test done");
        wr(io_settle_pkg::ADDR_IRQ_MASK, 32'h1);
        rd(io_settle_pkg::ADDR_IRQ_STAT);
        cmd(pat(32'h0, 8), io_settle_pkg::CMD_WRITE_OUT);
        wait_ack();
        chk(irq, 1, "irq raised");
        rd(io_settle_pkg::ADDR_IRQ_STAT);
        chk(irq, 0, "irq cleared");
        wr(io_settle_pkg::ADDR_IRQ_MASK, 32'h0);
        cmd(pat(32'h0, 8), io_settle_pkg::CMD_WRITE_OUT);
        wait_ack();
        chk(irq, 0, "irq masked");
        $display("interrupt test done");
        close_out();
    end
endmodule
